/* File: design/ppcr_regs.svh */
// Register offsets, field positions, reset values and timing counts for the port PHY controls
`ifndef PPCR_REGS_SVH
`define PPCR_REGS_SVH
`define PPCR_ADDR_W 8
`define PPCR_OFF_CTRL_P1 8'h1D
`define PPCR_OFF_CTRL_P2 8'h2D
`define PPCR_OFF_CTRL_P3 8'h3D
`define PPCR_OFF_CTRL_P4 8'h4D
`define PPCR_OFF_CTRL_RSVD 8'h5D
`define PPCR_OFF_ADV_P1 8'h1C
`define PPCR_OFF_ADV_P2 8'h2C
`define PPCR_OFF_ADV_P3 8'h3C
`define PPCR_OFF_ADV_P4 8'h4C
`define PPCR_ADV_HD100_BIT 2
`define PPCR_ADV_FD10_BIT 1
`define PPCR_ADV_HD10_BIT 0
`define PPCR_ADV_MASK 8'h07
`define PPCR_ADV_RESET 8'h07
`define PPCR_CTL_LED_OFF_BIT 7
`define PPCR_CTL_TX_DIS_BIT 6
`define PPCR_CTL_RENEG_BIT 5
`define PPCR_CTL_RSVD_BIT 4
`define PPCR_CTL_PWR_DN_BIT 3
`define PPCR_CTL_XOVR_DIS_BIT 2
`define PPCR_CTL_FORCE_MDI_BIT 1
`define PPCR_CTL_MAC_LOOP_BIT 0
`define PPCR_CTL_MASK 8'hEF
`define PPCR_CTL_RESET 8'h00
`define PPCR_RENEG_PULSE_CYC 1
`endif

/* File: design/ppcr_pkg.sv */
// Types shared by the port PHY control register block
package ppcr_pkg;
  typedef struct packed {
    logic led_off;
    logic tx_disable;
    logic power_down;
    logic auto_xover_dis;
    logic force_mdi;
    logic mac_loopback;
    logic adv_hd100;
    logic adv_fd10;
    logic adv_hd10;
  } ppcr_port_ctl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ppcr_bus_req_t;
endpackage

/* File: design/ppcr_port_ctl.sv */
// One port's control byte and advertisement bits with the restart pulse
`timescale 1ns/1ps
`include "ppcr_regs.svh"
module ppcr_port_ctl
  import ppcr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ctl_wr,
  input wire logic adv_wr,
  input wire logic [7:0] wdata,
  output logic [7:0] ctl_rd,
  output logic [7:0] adv_rd,
  output ppcr_port_ctl_t ctl,
  output logic renegotiate_link
);
  logic [7:0] ctl_ff;
  logic [7:0] adv_ff;
  logic reneg_ff;

  always_ff @(posedge clk)
  begin
    if (reset)
      ctl_ff <= `PPCR_CTL_RESET;
    else if (ctl_wr)
      ctl_ff <= wdata & `PPCR_CTL_MASK;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      adv_ff <= `PPCR_ADV_RESET;
    else if (adv_wr)
      adv_ff <= wdata & `PPCR_ADV_MASK;
  end

  // Restart is a one-cycle pulse; the stored bit keeps the written value but always reads back as zero
  always_ff @(posedge clk)
  begin
    if (reset)
      reneg_ff <= 1'b0;
    else
      reneg_ff <= ctl_wr & wdata[`PPCR_CTL_RENEG_BIT];
  end

  assign renegotiate_link = reneg_ff;
  assign ctl_rd = {ctl_ff[7:6], 1'b0, 1'b0, ctl_ff[3:0]};
  assign adv_rd = adv_ff & `PPCR_ADV_MASK;

  assign ctl.led_off = ctl_ff[`PPCR_CTL_LED_OFF_BIT];
  assign ctl.tx_disable = ctl_ff[`PPCR_CTL_TX_DIS_BIT];
  assign ctl.power_down = ctl_ff[`PPCR_CTL_PWR_DN_BIT];
  assign ctl.auto_xover_dis = ctl_ff[`PPCR_CTL_XOVR_DIS_BIT];
  assign ctl.force_mdi = ctl_ff[`PPCR_CTL_FORCE_MDI_BIT];
  assign ctl.mac_loopback = ctl_ff[`PPCR_CTL_MAC_LOOP_BIT];
  assign ctl.adv_hd100 = adv_ff[`PPCR_ADV_HD100_BIT];
  assign ctl.adv_fd10 = adv_ff[`PPCR_ADV_FD10_BIT];
  assign ctl.adv_hd10 = adv_ff[`PPCR_ADV_HD10_BIT];

  // A second pulse cycle is legal only when software wrote the restart bit again
  a_reneg_one_cycle: assert property (@(posedge clk) disable iff (reset)
    renegotiate_link |=> !renegotiate_link ||
      ($past(ctl_wr) && $past(wdata[`PPCR_CTL_RENEG_BIT])))
    else $error("restart pulse longer than one cycle");
endmodule

/* File: design/ppcr_top.sv */
// Port PHY control registers for four switch ports: control byte and advertisement bits
`timescale 1ns/1ps
`include "ppcr_regs.svh"
module ppcr_top
  import ppcr_pkg::*;
#(
  parameter int NPORTS = 4
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [NPORTS-1:0] led_link_n,
  input wire logic [NPORTS-1:0] led_act_n,
  input wire logic [NPORTS-1:0] led_speed_n,
  output logic [NPORTS-1:0] port_led_pin_low,
  output logic [NPORTS-1:0] port_led_pin_mid,
  output logic [NPORTS-1:0] port_led_pin_high,
  output logic [NPORTS-1:0] phy_tx_disable,
  output logic [NPORTS-1:0] phy_power_down,
  output logic [NPORTS-1:0] phy_renegotiate,
  output logic [NPORTS-1:0] phy_auto_xover_en,
  output logic [NPORTS-1:0] phy_mdi_mode,
  output logic [NPORTS-1:0] mac_loopback,
  output logic [NPORTS-1:0] adv_100_half,
  output logic [NPORTS-1:0] adv_10_full,
  output logic [NPORTS-1:0] adv_10_half
);
  ppcr_bus_req_t req;
  ppcr_port_ctl_t ctl [NPORTS];
  logic [7:0] ctl_rd [NPORTS];
  logic [7:0] adv_rd [NPORTS];
  logic [NPORTS-1:0] ctl_sel;
  logic [NPORTS-1:0] adv_sel;
  logic [7:0] nxt_rdata;
  logic [7:0] rdata_ff;
  logic [NPORTS-1:0] led_off_q;
  logic [NPORTS-1:0] led_low_ff;
  logic [NPORTS-1:0] led_mid_ff;
  logic [NPORTS-1:0] led_high_ff;
  logic [NPORTS-1:0] link_s1_ff;
  logic [NPORTS-1:0] link_s2_ff;
  logic [NPORTS-1:0] act_s1_ff;
  logic [NPORTS-1:0] act_s2_ff;
  logic [NPORTS-1:0] spd_s1_ff;
  logic [NPORTS-1:0] spd_s2_ff;

  // Upper nibble of the address selects the port, low nibble the register
  function automatic logic hits(input logic [7:0] addr, input int port, input logic [3:0] lo);
    hits = (addr[7:4] == 4'(port + 1)) && (addr[3:0] == lo);
  endfunction

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  genvar g;
  generate
    for (g = 0; g < NPORTS; g++)
    begin : g_port
      assign ctl_sel[g] = hits(req.addr, g, 4'(`PPCR_OFF_CTRL_P1 & 8'h0F));
      assign adv_sel[g] = hits(req.addr, g, 4'(`PPCR_OFF_ADV_P1 & 8'h0F));

      ppcr_port_ctl u_port (
        .clk(clk),
        .reset(reset),
        .ctl_wr(req.wr & ctl_sel[g]),
        .adv_wr(req.wr & adv_sel[g]),
        .wdata(req.wdata),
        .ctl_rd(ctl_rd[g]),
        .adv_rd(adv_rd[g]),
        .ctl(ctl[g]),
        .renegotiate_link(phy_renegotiate[g])
      );

      assign led_off_q[g] = ctl[g].led_off;
      assign phy_tx_disable[g] = ctl[g].tx_disable;
      assign phy_power_down[g] = ctl[g].power_down;
      assign phy_auto_xover_en[g] = !ctl[g].auto_xover_dis;
      assign phy_mdi_mode[g] = ctl[g].force_mdi;
      assign mac_loopback[g] = ctl[g].mac_loopback;
      assign adv_100_half[g] = ctl[g].adv_hd100;
      assign adv_10_full[g] = ctl[g].adv_fd10;
      assign adv_10_half[g] = ctl[g].adv_hd10;
    end
  endgenerate

  // Unmapped and reserved offsets, 0x5D among them, read as zero
  always_comb
  begin
    nxt_rdata = 8'h00;
    for (int i = 0; i < NPORTS; i++)
    begin
      if (ctl_sel[i])
        nxt_rdata = ctl_rd[i];
      if (adv_sel[i])
        nxt_rdata = adv_rd[i];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      rdata_ff <= 8'h00;
    else if (req.rd)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= 8'h00;
  end

  assign reg_rdata = rdata_ff;

  // LED indications come from pin-side logic, so they are synchronised first
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      link_s1_ff <= '1;
      link_s2_ff <= '1;
      act_s1_ff <= '1;
      act_s2_ff <= '1;
      spd_s1_ff <= '1;
      spd_s2_ff <= '1;
    end
    else
    begin
      link_s1_ff <= led_link_n;
      link_s2_ff <= link_s1_ff;
      act_s1_ff <= led_act_n;
      act_s2_ff <= act_s1_ff;
      spd_s1_ff <= led_speed_n;
      spd_s2_ff <= spd_s1_ff;
    end
  end

  // Blanked LEDs are driven high, which is the unlit level of these pins
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      led_low_ff <= '1;
      led_mid_ff <= '1;
      led_high_ff <= '1;
    end
    else
    begin
      led_low_ff <= link_s2_ff | led_off_q;
      led_mid_ff <= act_s2_ff | led_off_q;
      led_high_ff <= spd_s2_ff | led_off_q;
    end
  end

  assign port_led_pin_low = led_low_ff;
  assign port_led_pin_mid = led_mid_ff;
  assign port_led_pin_high = led_high_ff;

  a_led_blank_high: assert property (@(posedge clk) disable iff (reset)
    $past(led_off_q[0]) |-> port_led_pin_low[0] && port_led_pin_mid[0] && port_led_pin_high[0])
    else $error("blanked LEDs not driven high");

  a_txdis_follows_wr: assert property (@(posedge clk) disable iff (reset)
    reg_wr && reg_addr == `PPCR_OFF_CTRL_P1 |=> phy_tx_disable[0] == $past(reg_wdata[6]))
    else $error("transmit disable not written");

  a_reneg_on_write: assert property (@(posedge clk) disable iff (reset)
    reg_wr && reg_addr == `PPCR_OFF_CTRL_P2 && reg_wdata[5] |=> phy_renegotiate[1])
    else $error("restart pulse missing");

  a_reneg_reads_zero: assert property (@(posedge clk) disable iff (reset)
    reg_rd && reg_addr == `PPCR_OFF_CTRL_P3 |=> reg_rdata[5:4] == 2'b00)
    else $error("restart or reserved bit read as one");

  a_pwrdn_follows_wr: assert property (@(posedge clk) disable iff (reset)
    reg_wr && reg_addr == `PPCR_OFF_CTRL_P4 |=> phy_power_down[3] == $past(reg_wdata[3]))
    else $error("power down not written");

  a_xover_mode: assert property (@(posedge clk) disable iff (reset)
    reg_wr && reg_addr == `PPCR_OFF_CTRL_P1 |=>
      phy_auto_xover_en[0] != $past(reg_wdata[2]) && phy_mdi_mode[0] == $past(reg_wdata[1]))
    else $error("crossover mode not written");

  a_loop_follows_wr: assert property (@(posedge clk) disable iff (reset)
    reg_wr && reg_addr == `PPCR_OFF_CTRL_P2 |=> mac_loopback[1] == $past(reg_wdata[0]))
    else $error("loopback not written");

  a_rsvd_reads_zero: assert property (@(posedge clk) disable iff (reset)
    reg_rd && reg_addr == `PPCR_OFF_CTRL_RSVD |=> reg_rdata == 8'h00)
    else $error("reserved offset read nonzero");

  a_adv_default: assert property (@(posedge clk)
    $past(reset) |-> adv_100_half == '1 && adv_10_full == '1 && adv_10_half == '1)
    else $error("advertisement default not one");

  // Every port is checked against bus traffic aimed at its own offsets; the offsets are
  // worked out here rather than taken from the decoder, so a decode fault is caught too
  for (genvar k = 0; k < NPORTS; k++)
  begin : g_port_chk
    localparam logic [7:0] CTL_OFF = 8'(`PPCR_OFF_CTRL_P1 + 8'h10 * k);
    localparam logic [7:0] ADV_OFF = 8'(`PPCR_OFF_ADV_P1 + 8'h10 * k);

    a_adv_write_lands: assert property (@(posedge clk) disable iff (reset)
      reg_wr && reg_addr == ADV_OFF |=>
        {adv_100_half[k], adv_10_full[k], adv_10_half[k]} == $past(reg_wdata[2:0]))
      else $error("advertisement write lost");

    a_adv_hold_port: assert property (@(posedge clk) disable iff (reset)
      !(reg_wr && reg_addr == ADV_OFF) |=>
        $stable({adv_100_half[k], adv_10_full[k], adv_10_half[k]}))
      else $error("advertisement changed without a write");

    a_led_blank_port: assert property (@(posedge clk) disable iff (reset)
      reg_wr && reg_addr == CTL_OFF && reg_wdata[7] |=> ##1
        port_led_pin_low[k] && port_led_pin_mid[k] && port_led_pin_high[k])
      else $error("port LEDs not blanked after write");

    a_txdis_port: assert property (@(posedge clk) disable iff (reset)
      reg_wr && reg_addr == CTL_OFF |=> phy_tx_disable[k] == $past(reg_wdata[6]))
      else $error("port transmit disable not written");

    a_reneg_port: assert property (@(posedge clk) disable iff (reset)
      reg_wr && reg_addr == CTL_OFF |=> phy_renegotiate[k] == $past(reg_wdata[5]))
      else $error("port restart pulse wrong");

    // Writing zero to the restart bit must never start a negotiation
    a_reneg_needs_write: assert property (@(posedge clk) disable iff (reset)
      phy_renegotiate[k] |->
        $past(reg_wr) && $past(reg_addr) == CTL_OFF && $past(reg_wdata[5]))
      else $error("restart pulse without a restart write");

    a_pwrdn_port: assert property (@(posedge clk) disable iff (reset)
      reg_wr && reg_addr == CTL_OFF |=> phy_power_down[k] == $past(reg_wdata[3]))
      else $error("port power down not written");

    a_xover_port: assert property (@(posedge clk) disable iff (reset)
      reg_wr && reg_addr == CTL_OFF |=>
        phy_auto_xover_en[k] != $past(reg_wdata[2]) && phy_mdi_mode[k] == $past(reg_wdata[1]))
      else $error("port crossover mode not written");

    a_loop_port: assert property (@(posedge clk) disable iff (reset)
      reg_wr && reg_addr == CTL_OFF |=> mac_loopback[k] == $past(reg_wdata[0]))
      else $error("port loopback not written");

    a_ctl_read_port: assert property (@(posedge clk) disable iff (reset)
      reg_rd && reg_addr == CTL_OFF |=> reg_rdata[5:4] == 2'b00 &&
        reg_rdata[6] == $past(phy_tx_disable[k]) && reg_rdata[3] == $past(phy_power_down[k]) &&
        reg_rdata[2] != $past(phy_auto_xover_en[k]) && reg_rdata[1] == $past(phy_mdi_mode[k]) &&
        reg_rdata[0] == $past(mac_loopback[k]))
      else $error("port control byte read back wrong");

    a_adv_read_port: assert property (@(posedge clk) disable iff (reset)
      reg_rd && reg_addr == ADV_OFF |=> reg_rdata ==
        {5'h00, $past(adv_100_half[k]), $past(adv_10_full[k]), $past(adv_10_half[k])})
      else $error("port advertisement read back wrong");

    // Writes to other ports, reserved or unmapped places leave this port alone
    a_ctl_hold_port: assert property (@(posedge clk) disable iff (reset)
      !(reg_wr && reg_addr == CTL_OFF) |=> $stable({phy_tx_disable[k], phy_power_down[k],
        phy_auto_xover_en[k], phy_mdi_mode[k], mac_loopback[k]}))
      else $error("port controls changed without a write");
  end

  c_reneg: cover property (@(posedge clk) disable iff (reset) phy_renegotiate[0]);
  c_forced_mdix: cover property (@(posedge clk) disable iff (reset)
    !phy_auto_xover_en[0] && !phy_mdi_mode[0]);
  c_led_off: cover property (@(posedge clk) disable iff (reset) led_off_q[2]);
  c_forced_mdi: cover property (@(posedge clk) disable iff (reset)
    !phy_auto_xover_en[1] && phy_mdi_mode[1]);
  c_back_to_back: cover property (@(posedge clk) disable iff (reset) reg_wr ##1 reg_rd);
endmodule

/* File: verif/ppcr_top_test.sv */
// Self-checking bench for the port PHY control register block
`timescale 1ns/1ps
module ppcr_top_test;
  logic clk;
  logic reset;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic [3:0] lnk_n, act_n, spd_n;
  logic [3:0] led_lo, led_mid, led_hi, tx_dis, pwr_dn, reneg, xen, mdi, loopb, a100h, a10f, a10h;
  logic [7:0] d;
  logic [3:0] m;
  int err_count;
  int comparisons;
  int cycles;

  ppcr_top #(.NPORTS(4)) i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .led_link_n(lnk_n), .led_act_n(act_n), .led_speed_n(spd_n),
    .port_led_pin_low(led_lo), .port_led_pin_mid(led_mid), .port_led_pin_high(led_hi),
    .phy_tx_disable(tx_dis), .phy_power_down(pwr_dn), .phy_renegotiate(reneg),
    .phy_auto_xover_en(xen), .phy_mdi_mode(mdi), .mac_loopback(loopb),
    .adv_100_half(a100h), .adv_10_full(a10f), .adv_10_half(a10h));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under 400 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, then fall to zero
  task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(name, reg_rdata, exp);
    @(posedge clk);
    #1;
    chk("rdata_idle", reg_rdata, 8'h00);
  endtask

  task automatic outs(input logic [3:0] c);
    chk("tx_dis", {4'h0, tx_dis}, {4'h0, c});
    chk("pwr_dn", {4'h0, pwr_dn}, {4'h0, c});
    chk("xover_en", {4'h0, xen}, {4'h0, ~c});
    chk("mdi", {4'h0, mdi}, {4'h0, c});
    chk("loop", {4'h0, loopb}, {4'h0, c});
    chk("leds", {4'h0, led_lo & led_mid & led_hi}, {4'h0, c});
    chk("leds_any", {4'h0, led_lo | led_mid | led_hi}, {4'h0, c});
  endtask

  task automatic advs(input string name, input logic [3:0] e);
    chk(name, {4'h0, a100h}, {4'h0, e});
    chk(name, {4'h0, a10f}, {4'h0, e});
    chk(name, {4'h0, a10h}, {4'h0, e});
  endtask

  initial
  begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    lnk_n = 4'h0;
    act_n = 4'h0;
    spd_n = 4'h0;
    m = 4'h0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    outs(4'h0);
    advs("adv", 4'hF);
    for (int p = 1; p <= 4; p++)
    begin
      rdchk("ctl_rst", {p[3:0], 4'hD}, 8'h00);
      rdchk("adv_rst", {p[3:0], 4'hC}, 8'h07);
      wr({p[3:0], 4'hD}, 8'hFF);
      m[p-1] = 1'b1;
      chk("reneg_hi", {4'h0, reneg}, 8'h01 << (p - 1));
      // LED pins are registered, so blanking shows one clock after the write
      @(posedge clk);
      #1;
      chk("reneg_lo", {4'h0, reneg}, 8'h00);
      outs(m);
      rdchk("ctl_rb", {p[3:0], 4'hD}, 8'hCF);
      wr({p[3:0], 4'hC}, 8'h00);
      advs("adv_clr", ~m);
      rdchk("adv_rb", {p[3:0], 4'hC}, 8'h00);
    end
    // Reserved and unmapped places must neither answer nor disturb the ports
    wr(8'h5D, 8'h00);
    wr(8'h0D, 8'h00);
    rdchk("rsvd", 8'h5D, 8'h00);
    rdchk("unmapped", 8'h0D, 8'h00);
    outs(4'hF);
    wr(8'h1D, 8'h04);
    chk("reneg_w0", {4'h0, reneg}, 8'h00);
    chk("mdix", {6'h00, xen[0], mdi[0]}, 8'h00);
    wr(8'h1D, 8'h06);
    chk("mdi_f", {6'h00, xen[0], mdi[0]}, 8'h01);
    wr(8'h1D, 8'h00);
    outs(4'hE);
    wr(8'h1C, 8'hFD);
    chk("adv_p1", {5'h00, a100h[0], a10f[0], a10h[0]}, 8'h05);
    rdchk("adv_p1_rb", 8'h1C, 8'h05);
    report_and_stop();
  end
endmodule
